/* File: core/rcd_pkg.sv */
// Shared constants for the rate-converting clock divider block.
// Assumes a single 100 MHz system clock standing in for the master oscillator.
package rcd_pkg;
	// System clock rate and the 1 kHz base tick derived from it
	localparam int unsigned SYS_CLK_HZ = 100000000;
	localparam int unsigned BASE_TICK_HZ = 1000;
	localparam int unsigned BASE_TICK_CYC = SYS_CLK_HZ / BASE_TICK_HZ;
	localparam int CNT_W = 16;
	localparam int ACC_W = 18;
	localparam int SKEW_W = 4;
	localparam int SKEW_TAPS = 16;
	localparam int N_DIV = 4;
	localparam int N_SE = 2;
	// Reference input mode register
	localparam logic [7:0] REF_CFG_ADDR = 8'h0A;
	localparam logic [7:0] REF_CFG_RST = 8'h01;
	localparam int REF0_DIFF_BIT = 0;
	localparam int REF1_DIFF_BIT = 1;
	// Master clock strap code
	localparam logic [1:0] STRAP_24M576 = 2'h3;
	// Output driver source selection
	localparam logic [1:0] DRV_DIVIDER = 2'h0;
	localparam logic [1:0] DRV_OSC = 2'h1;
	localparam logic [1:0] DRV_XTAL = 2'h2;
	// Synchroniser vector layout
	localparam int SY_REF = 0;
	localparam int SY_STRAP = 2;
	localparam int SY_STOP = 4;
	localparam int SY_OSC = 6;
	localparam int SY_XTAL = 7;
	localparam int SY_W = 8;
	// Ratio reset value
	localparam logic [CNT_W-1:0] RATIO_RST = 16'h0001;
	// Strap capture sequence
	typedef enum logic [1:0] {ST_HOLD, ST_CAPT, ST_RUN} rcd_strap_e;
endpackage

/* File: core/rcd_rate_stage.sv */
// One fractional rate stage: out rate = in rate * mul / div.
// Assumes in_tick is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module rcd_rate_stage
	import rcd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_tick,
	input wire logic [CNT_W-1:0] mul,
	input wire logic [CNT_W-1:0] div,
	output logic out_tick_ff
);
	// Phase accumulator and the ratio in use
	logic [ACC_W-1:0] acc_ff;
	logic [CNT_W-1:0] mul_act_ff;
	logic [CNT_W-1:0] div_act_ff;
	logic primed_ff;
	// Division by zero is treated as division by one
	wire [CNT_W-1:0] div_safe = (div_act_ff == '0) ? RATIO_RST : div_act_ff;
	wire fire = acc_ff >= {2'h0, div_safe}; // [R1] [R2]
	wire [ACC_W-1:0] add_term = in_tick ? {2'h0, mul_act_ff} : '0;
	wire [ACC_W-1:0] sub_term = fire ? {2'h0, div_safe} : '0;
	wire [ACC_W-1:0] nxt_acc = acc_ff + add_term - sub_term;
	// New ratio only at an output boundary or the first cycle out of reset, so no short period appears;
	// an idle stage (zero multiplier) has no boundary and takes it at once
	wire take = fire || !primed_ff || (mul_act_ff == '0); // [R22]

	// Accumulate, emit and reload
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_ff <= '0;
			mul_act_ff <= RATIO_RST;
			div_act_ff <= RATIO_RST;
			primed_ff <= 1'b0;
			out_tick_ff <= 1'b0;
		end else begin
			acc_ff <= nxt_acc;
			out_tick_ff <= fire;
			primed_ff <= 1'b1;
			if (take) begin
				mul_act_ff <= mul;
				div_act_ff <= div;
			end
		end
	end

	a_ratio_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R22]
		(primed_ff && !fire && mul_act_ff != '0) |=> $stable(mul_act_ff) && $stable(div_act_ff))
		else $error("ratio changed between boundaries");
	a_tick_cause: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
		$rose(out_tick_ff) |-> $past(acc_ff) >= {2'h0, $past(div_safe)})
		else $error("output tick without accumulator overflow");
endmodule
`default_nettype wire

/* File: core/rcd_out_div.sv */
// One 50% duty output divider with optional coarse skew and stop.
// Assumes tick is a one-cycle pulse from the synthesis engine.
`timescale 1ns/1ps
`default_nettype none
module rcd_out_div
	import rcd_pkg::*;
#(
	parameter bit SE = 1'b0
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic [CNT_W-1:0] half_cnt,
	input wire logic [SKEW_W-1:0] skew,
	input wire logic stop,
	input wire logic stop_lvl,
	output logic clk_out_ff
);
	// Half-period counter and current level
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] half_act_ff;
	logic level_ff;
	logic [SKEW_TAPS-1:0] dly_ff;
	wire [CNT_W-1:0] half_safe = (half_act_ff == '0) ? RATIO_RST : half_act_ff;
	// Freeze only once the chosen level is reached: no runt pulse
	wire frozen = SE && stop && (level_ff == stop_lvl); // [R11] [R21]
	wire at_end = tick && (cnt_ff == half_safe - RATIO_RST);
	wire toggle = at_end && !frozen; // [R7] [R8] [R9]
	// Skew taps exist on single-ended dividers only
	wire [SKEW_W-1:0] skew_eff = SE ? skew : '0;
	wire nxt_out = (skew_eff == '0) ? level_ff : dly_ff[skew_eff - 4'h1]; // [R10]

	// Count ticks, toggle at half period, reload ratio at the edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_ff <= '0;
			half_act_ff <= RATIO_RST;
			level_ff <= 1'b0;
		end else if (frozen) begin
			cnt_ff <= '0;
		end else if (toggle) begin
			cnt_ff <= '0;
			level_ff <= !level_ff;
			half_act_ff <= half_cnt; // [R22]
		end else if (tick) begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// Delay line of whole sys_clk periods
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dly_ff <= '0;
			clk_out_ff <= 1'b0;
		end else begin
			dly_ff <= {dly_ff[SKEW_TAPS-2:0], level_ff};
			clk_out_ff <= nxt_out;
		end
	end

	a_level_cause: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
		(level_ff != $past(level_ff)) |-> $past(tick) && !$past(frozen))
		else $error("divider level changed without a terminal tick");
	a_stop_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R21]
		frozen |=> level_ff == $past(stop_lvl))
		else $error("stopped divider left its stop level");
endmodule
`default_nettype wire

/* File: core/rcd_top.sv */
// Rate conversion, synthesis ratio, output dividers and strap capture.
// Assumes pins arrive asynchronously; ratio and control inputs are on sys_clk.
`timescale 1ns/1ps
`default_nettype none
//
// Function
// [R1] Rate conversion via 16-bit forward/feedback dividers
// [R2] Ratio may scale frequency up or down
// [R3] Switch between normal and FEC ratio
// [R4] Single or cascaded two-step ratio conversion
// [R5] Synthesis output is M over N kHz
// [R6] Oscillator trim accepted only while locked
// [R7] Four independent output divider engines
// [R8] Differential dividers give 50% duty clocks
// [R9] Other dividers give 50% duty clocks
// [R10] Single-ended outputs skew in whole clock steps
// [R11] Single-ended outputs stop on chosen edge
// [R12] Mux routes oscillator or crystal to drivers
// [R13] Reference modes reset diff/single, register 0x0A
// [R14] Master clock strap sampled after reset release
// [R15] System holds straps high 50 ms
// [R16] Strap value 3 selects 24.576 MHz
// [R17] Monitor measures references against master clock; only ref0 is counted here
// [R18] Free-run and holdover use master clock only
// [R19] Stop pin ORed with stop register bit
// [R20] System holds reset at least 2 ms
// [R21] Stop completes half period, restarts same level
// [R22] New ratios taken at cycle boundary
module rcd_top
	import rcd_pkg::*;
#(
	parameter int unsigned TICK_CYC = BASE_TICK_CYC
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] ref_pin,
	input wire logic [1:0] strap_pin,
	input wire logic [N_SE-1:0] stop_pin,
	input wire logic osc_pin,
	input wire logic xtal_pin,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_we,
	input wire logic dpll_locked,
	input wire logic fec_sel,
	input wire logic cascade_en,
	input wire logic [CNT_W-1:0] fwd_div_norm,
	input wire logic [CNT_W-1:0] fb_div_norm,
	input wire logic [CNT_W-1:0] fwd_div_fec,
	input wire logic [CNT_W-1:0] fb_div_fec,
	input wire logic [CNT_W-1:0] fwd_div_casc,
	input wire logic [CNT_W-1:0] fb_div_casc,
	input wire logic [CNT_W-1:0] synth_m,
	input wire logic [CNT_W-1:0] synth_n,
	input wire logic [7:0] dco_trim,
	input wire logic [N_DIV-1:0][CNT_W-1:0] div_half,
	input wire logic [N_SE-1:0][SKEW_W-1:0] se_skew,
	input wire logic [N_SE-1:0] stop_reg,
	input wire logic [N_SE-1:0] stop_edge,
	input wire logic [N_SE-1:0] stop_pin_en,
	input wire logic [N_DIV-1:0][1:0] drv_sel,
	output logic [7:0] cfg_rdata_ff,
	output logic [1:0] ref_diff_ff,
	output logic [1:0] strap_ff,
	output logic mclk_ok_ff,
	output logic dpll_tick_ff,
	output logic [CNT_W-1:0] ref_freq_ff,
	output logic [N_DIV-1:0] clk_out_ff
);
	// Two-stage synchroniser plus an edge history stage
	logic [SY_W-1:0] sync_a_ff;
	logic [SY_W-1:0] sync_b_ff;
	logic [SY_W-1:0] hist_ff;
	// Base tick counter and strap sequence
	logic [16:0] tick_cnt_ff;
	logic base_tick_ff;
	rcd_strap_e strap_st_ff;
	rcd_strap_e nxt_strap_st;
	// Reference input mode register
	logic [7:0] ref_cfg_ff;
	// Reference edge counter for the monitor
	logic [CNT_W-1:0] mon_cnt_ff;

	// Rising edges of synchronised references
	wire [1:0] ref_rise = sync_b_ff[SY_REF +: 2] & ~hist_ff[SY_REF +: 2];
	wire [1:0] strap_s = sync_b_ff[SY_STRAP +: 2];
	wire [N_SE-1:0] stop_s = sync_b_ff[SY_STOP +: N_SE];
	wire osc_s = sync_b_ff[SY_OSC];
	wire xtal_s = sync_b_ff[SY_XTAL];
	wire [16:0] tick_last = 17'(TICK_CYC - 1);

	// Register decode
	wire cfg_hit = (cfg_addr == REF_CFG_ADDR);
	wire cfg_wr = cfg_we && cfg_hit; // [R13]
	wire [7:0] nxt_rdata = cfg_hit ? ref_cfg_ff : 8'h00;

	// Without lock the DPLL runs from the master-derived base tick
	wire src_tick = dpll_locked ? ref_rise[0] : base_tick_ff; // [R18]
	// Normal or FEC ratio pair, taken up inside the stage at a boundary
	wire [CNT_W-1:0] a_mul = fec_sel ? fb_div_fec : fb_div_norm; // [R3]
	wire [CNT_W-1:0] a_div = fec_sel ? fwd_div_fec : fwd_div_norm; // [R3]
	wire a_tick;
	wire b_tick;
	wire nxt_dpll_tick = cascade_en ? b_tick : a_tick; // [R4]

	// Trim ignored while free-running or in holdover
	wire [CNT_W-1:0] trim_eff = dpll_locked ? {{8{dco_trim[7]}}, dco_trim} : '0; // [R6]
	wire [CNT_W-1:0] m_eff = synth_m + trim_eff; // [R5]
	wire synth_tick;
	// Stop request: register bit OR enabled pin
	wire [N_SE-1:0] se_stop = stop_reg | (stop_pin_en & stop_s); // [R19]
	wire [N_DIV-1:0] div_out;
	logic [N_DIV-1:0] nxt_clk_out;

	// Synchronisers; first stage feeds only the second. They run through
	// reset so the strap capture right after release sees the held pins
	always_ff @(posedge sys_clk) begin
		sync_a_ff <= {xtal_pin, osc_pin, stop_pin, strap_pin, ref_pin};
		sync_b_ff <= sync_a_ff;
		hist_ff <= sync_b_ff;
	end

	// Base 1 kHz tick from the master clock
	always_ff @(posedge sys_clk) begin
		if (rst || tick_cnt_ff == tick_last) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 17'h00001;
		end
	end

	// Tick pulse registered off the counter wrap
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			base_tick_ff <= 1'b0;
		end else begin
			base_tick_ff <= (tick_cnt_ff == tick_last);
		end
	end

	// Strap sequence: hold in reset, capture once, then run
	always_comb begin
		nxt_strap_st = strap_st_ff;
		case (strap_st_ff)
			ST_HOLD: nxt_strap_st = ST_CAPT;
			ST_CAPT: nxt_strap_st = ST_RUN;
			ST_RUN: nxt_strap_st = ST_RUN;
			default: nxt_strap_st = ST_HOLD;
		endcase
	end

	// Strap state and captured value; reset drives constants only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			strap_st_ff <= ST_HOLD;
			strap_ff <= 2'h0;
			mclk_ok_ff <= 1'b0;
		end else begin
			strap_st_ff <= nxt_strap_st;
			if (strap_st_ff == ST_CAPT) begin
				strap_ff <= strap_s; // [R14]
				mclk_ok_ff <= (strap_s == STRAP_24M576); // [R16]
			end
		end
	end

	// Reference mode register and read port
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ref_cfg_ff <= REF_CFG_RST; // [R13]
			cfg_rdata_ff <= 8'h00;
		end else begin
			if (cfg_wr) begin
				ref_cfg_ff <= cfg_wdata;
			end
			cfg_rdata_ff <= nxt_rdata;
		end
	end

	// Mode outputs to the input buffers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ref_diff_ff <= 2'h1;
		end else begin
			ref_diff_ff <= {ref_cfg_ff[REF1_DIFF_BIT], ref_cfg_ff[REF0_DIFF_BIT]};
		end
	end

	// Count ref0 edges per master-derived window of 1 ms
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mon_cnt_ff <= '0;
			ref_freq_ff <= '0;
		end else if (base_tick_ff) begin
			ref_freq_ff <= mon_cnt_ff; // [R17]
			mon_cnt_ff <= {15'h0000, ref_rise[0]};
		end else if (ref_rise[0] && mon_cnt_ff != 16'hFFFF) begin
			mon_cnt_ff <= mon_cnt_ff + 16'h0001; // Saturates, no wrap
		end
	end

	// First ratio stage: normal or FEC
	rcd_rate_stage u_stage_a (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_tick(src_tick),
		.mul(a_mul),
		.div(a_div),
		.out_tick_ff(a_tick)
	);

	// Optional cascaded second ratio stage
	rcd_rate_stage u_stage_b (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_tick(a_tick),
		.mul(fb_div_casc),
		.div(fwd_div_casc),
		.out_tick_ff(b_tick)
	);

	// Synthesis engine: M/N times the 1 kHz base
	rcd_rate_stage u_synth (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_tick(base_tick_ff),
		.mul(m_eff),
		.div(synth_n),
		.out_tick_ff(synth_tick)
	);

	// DPLL output tick
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dpll_tick_ff <= 1'b0;
		end else begin
			dpll_tick_ff <= nxt_dpll_tick;
		end
	end

	// Dividers 0,1 differential; 2,3 single-ended with skew and stop
	genvar gi;
	generate
		for (gi = 0; gi < N_DIV; gi++) begin : g_div
			localparam bit IS_SE = (gi >= N_DIV - N_SE);
			localparam int SI = IS_SE ? gi - (N_DIV - N_SE) : 0;
			rcd_out_div #(.SE(IS_SE)) u_div (
				.sys_clk(sys_clk),
				.rst(rst),
				.tick(synth_tick),
				.half_cnt(div_half[gi]),
				.skew(IS_SE ? se_skew[SI] : 4'h0),
				.stop(IS_SE ? se_stop[SI] : 1'b0),
				.stop_lvl(IS_SE ? stop_edge[SI] : 1'b0),
				.clk_out_ff(div_out[gi])
			);
		end
	endgenerate

	// Output mux per driver
	always_comb begin
		nxt_clk_out = '0;
		for (int i = 0; i < N_DIV; i++) begin
			case (drv_sel[i])
				DRV_DIVIDER: nxt_clk_out[i] = div_out[i];
				DRV_OSC: nxt_clk_out[i] = osc_s; // [R12]
				DRV_XTAL: nxt_clk_out[i] = xtal_s; // [R12]
				default: nxt_clk_out[i] = 1'b0;
			endcase
		end
	end

	// Registered driver outputs
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clk_out_ff <= '0;
		end else begin
			clk_out_ff <= nxt_clk_out;
		end
	end

	a_cfg_reset: assert property (@(posedge sys_clk) // [R13]
		rst |=> ref_cfg_ff == REF_CFG_RST)
		else $error("reference mode register not at reset value");
	a_strap_capt: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
		strap_st_ff == ST_CAPT |=> mclk_ok_ff == ($past(strap_s) == STRAP_24M576))
		else $error("master clock strap decoded wrongly");
	a_strap_time: assert property (@(posedge sys_clk) // [R14]
		$fell(rst) |-> strap_st_ff == ST_HOLD ##1 strap_st_ff == ST_CAPT ##1 strap_st_ff == ST_RUN)
		else $error("strap not sampled right after reset release");
	a_trim_gate: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
		!dpll_locked |-> m_eff == synth_m)
		else $error("trim applied while not locked");
	a_stop_or: assert property (@(posedge sys_clk) disable iff (rst) // [R19]
		(stop_reg[0] || (stop_pin_en[0] && stop_s[0])) |-> se_stop[0])
		else $error("stop pin not ORed into stop request");
	a_mon_latch: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
		base_tick_ff |=> ref_freq_ff == $past(mon_cnt_ff))
		else $error("reference count not latched at window end");
	a_diff_follow: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
		ref_diff_ff == {$past(ref_cfg_ff[REF1_DIFF_BIT]), $past(ref_cfg_ff[REF0_DIFF_BIT])})
		else $error("reference mode outputs do not follow the register");
endmodule
`default_nettype wire

/* File: testbench/rcd_far_end.sv */
// Far-side model: reference clocks, oscillator and crystal pins, strap pull-ups.
// Assumes rst comes from the bench and sys_clk is the 100 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module rcd_far_end #(
	parameter int R0_HALF = 20,
	parameter int R1_HALF = 35,
	parameter int OSC_HALF = 115,
	parameter int XT_HALF = 185,
	parameter int HOLD_CYC = 50
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] strap_val,
	output logic [1:0] ref_pin,
	output logic osc_pin,
	output logic xtal_pin,
	output logic [1:0] strap_pin
);
	int hold_ff; // Cycles since reset release, saturating
	// Free-running sources; periods unrelated to sys_clk on purpose
	initial begin
		ref_pin = 2'h0;
		osc_pin = 1'b0;
		xtal_pin = 1'b0;
		fork
			forever #R0_HALF ref_pin[0] = ~ref_pin[0];
			forever #R1_HALF ref_pin[1] = ~ref_pin[1];
			forever #OSC_HALF osc_pin = ~osc_pin;
			forever #XT_HALF xtal_pin = ~xtal_pin;
		join
	end
	// Hold counter, so a late strap sample would see the pull-ups
	always_ff @(posedge sys_clk) begin
		if (rst) hold_ff <= 0;
		else if (hold_ff < HOLD_CYC) hold_ff <= hold_ff + 1;
	end
	// Straps driven through reset and the hold time, then released high
	assign strap_pin = (rst || hold_ff < HOLD_CYC) ? strap_val : 2'h3;
endmodule
`default_nettype wire

/* File: testbench/rate_converting_clock_dividers_bench.sv */
// Self-checking bench for the rate-converting clock divider top.
// Assumes rcd_far_end supplies reference, oscillator and strap pins.
`timescale 1ns/1ps
`default_nettype none
module rate_converting_clock_dividers_bench
	import rcd_pkg::*;
;
	localparam int TK = 20; // Shortened base tick, keeps runs short
	localparam int W = 2000; // Measure window, 100 base ticks
	localparam int WR = 2880; // Ratio window: 144 base ticks, whole periods of every random pattern
	localparam int R0H = 20; // Ref0 half period in ns
	localparam int OH = 115; // Oscillator half period in ns
	localparam int XH = 185; // Crystal half period in ns
	logic sys_clk, rst, osc_pin, xtal_pin, cfg_we, dpll_locked, fec_sel, cascade_en;
	logic mclk_ok_ff, dpll_tick_ff;
	logic [1:0] ref_pin, strap_pin, stop_pin, stop_reg, stop_edge, stop_pin_en;
	logic [1:0] strap_val, ref_diff_ff, strap_ff;
	logic [7:0] cfg_addr, cfg_wdata, dco_trim, cfg_rdata_ff, d;
	logic [CNT_W-1:0] fwd_div_norm, fb_div_norm, fwd_div_fec, fb_div_fec, synth_m, synth_n;
	logic [CNT_W-1:0] fwd_div_casc, fb_div_casc, ref_freq_ff;
	logic [N_DIV-1:0][CNT_W-1:0] div_half;
	logic [N_SE-1:0][SKEW_W-1:0] se_skew;
	logic [N_DIV-1:0][1:0] drv_sel;
	logic [N_DIV-1:0] clk_out_ff;
	int err_count, comparisons, seed, c, hi, lo, k, i, a;
	rcd_top #(.TICK_CYC(TK)) rcd_top_inst (.sys_clk, .rst, .ref_pin, .strap_pin, .stop_pin,
		.osc_pin, .xtal_pin, .cfg_addr, .cfg_wdata, .cfg_we, .dpll_locked, .fec_sel,
		.cascade_en, .fwd_div_norm, .fb_div_norm, .fwd_div_fec, .fb_div_fec, .fwd_div_casc,
		.fb_div_casc, .synth_m, .synth_n, .dco_trim, .div_half, .se_skew, .stop_reg,
		.stop_edge, .stop_pin_en, .drv_sel, .cfg_rdata_ff, .ref_diff_ff, .strap_ff,
		.mclk_ok_ff, .dpll_tick_ff, .ref_freq_ff, .clk_out_ff);
	rcd_far_end #(.R0_HALF(R0H), .OSC_HALF(OH), .XT_HALF(XH)) rcd_far_end_inst (.sys_clk,
		.rst, .strap_val, .ref_pin, .osc_pin, .xtal_pin, .strap_pin);
	// Free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Counts and verdict
	task automatic tally_and_finish;
		$display("errors=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Asynchronous sources make counts jitter, so allow a small slack
	task automatic near(input logic [31:0] seen, input int exp, input int tol);
		check((!$isunknown(seen) && $signed(seen) >= exp - tol &&
			$signed(seen) <= exp + tol) ? exp : seen, exp);
	endtask
	// Rising edges of an output (sel 0-3) or DPLL pulses (sel 4) over n cycles
	task automatic count(input int sel, input int n, output int cnt);
		logic p, v;
		cnt = 0;
		p = 1'b1;
		repeat (n) begin
			@(posedge sys_clk);
			v = (sel == 4) ? dpll_tick_ff : clk_out_ff[sel[1:0]];
			if (v === 1'b1 && (sel == 4 || p === 1'b0)) cnt++;
			p = v;
		end
	endtask
	// Cycles until an output reaches a level; bounded
	task automatic wait_lvl(input int sel, input logic lvl, output int cnt);
		cnt = 0;
		while (clk_out_ff[sel[1:0]] !== lvl) begin
			@(posedge sys_clk);
			cnt++;
			if (cnt > 3000) begin
				err_count++;
				tally_and_finish;
			end
		end
	endtask
	// One register access; returns once read data has settled
	task automatic reg_io(input logic [7:0] ad, input logic [7:0] wd, input logic we);
		cfg_addr <= ad;
		cfg_wdata <= wd;
		cfg_we <= we;
		@(posedge sys_clk);
		cfg_we <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic do_reset(input logic [1:0] sv);
		strap_val <= sv;
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		check(strap_ff, sv);
		check(mclk_ok_ff, sv == 2'h3);
		check(ref_diff_ff, 2'h1);
	endtask
	// Expected rate; a zero divisor counts as one, a zero multiplier stops the stage
	function automatic int ratio(int base, logic [15:0] m, logic [15:0] dv);
		return base * m / (dv == 0 ? 1 : dv);
	endfunction
	function automatic logic [15:0] rnd();
		return 16'($unsigned($random(seed)) % 5);
	endfunction
	// Main sequence
	initial begin
		seed = 32'ha5b8;
		err_count = 0;
		comparisons = 0;
		rst = 1'b1;
		strap_val = 2'h3;
		{cfg_we, dpll_locked, fec_sel, cascade_en, cfg_addr, cfg_wdata, dco_trim} = '0;
		{stop_pin, stop_reg, stop_edge, stop_pin_en, se_skew, drv_sel} = '0;
		{fwd_div_norm, fb_div_norm, fwd_div_fec, fb_div_fec} = {4{16'h0001}};
		{fwd_div_casc, fb_div_casc, synth_m, synth_n} = {4{16'h0001}};
		div_half = {4{16'h0001}};
		do_reset(2'h3);
		repeat (60) @(posedge sys_clk);
		check(strap_ff, 2'h3);
		// Register default, write-back, refused address
		reg_io(REF_CFG_ADDR, 8'h00, 1'b0);
		check(cfg_rdata_ff, 8'h01);
		d = 8'($random(seed));
		reg_io(REF_CFG_ADDR, d, 1'b1);
		check(cfg_rdata_ff, d);
		check(ref_diff_ff, d[1:0]);
		reg_io(8'h0B, ~d, 1'b1);
		check(cfg_rdata_ff, 8'h00);
		reg_io(REF_CFG_ADDR, 8'h00, 1'b0);
		check(cfg_rdata_ff, d);
		// Ratio modes: plain 255/238, FEC 66/64 cascaded, then random pairs
		for (i = 0; i < 6; i++) begin
			fec_sel <= i[0];
			cascade_en <= (i == 1) || i[1];
			fb_div_norm <= (i == 0) ? 16'd255 : rnd();
			fwd_div_norm <= (i == 0) ? 16'd238 : rnd();
			fb_div_fec <= (i == 1) ? 16'd66 : rnd();
			fwd_div_fec <= (i == 1) ? 16'd64 : rnd();
			fb_div_casc <= (i == 1) ? 16'd255 : rnd();
			fwd_div_casc <= (i == 1) ? 16'd238 : rnd();
			// Slow old ratios hand over only at their next output
			repeat (500) @(posedge sys_clk);
			count(4, WR, c);
			hi = cascade_en ? int'(fb_div_casc) : 1;
			lo = (cascade_en && fwd_div_casc != 0) ? int'(fwd_div_casc) : 1;
			a = fec_sel ? ratio(WR / TK * hi, fb_div_fec, fwd_div_fec) :
				ratio(WR / TK * hi, fb_div_norm, fwd_div_norm);
			near(c, a / lo, 3);
		end
		// Unlocked then locked: DPLL source and trim both switch
		{fec_sel, cascade_en} <= 2'h0;
		fb_div_norm <= 16'd1;
		fwd_div_norm <= 16'd8;
		synth_m <= 16'd4;
		synth_n <= 16'd4;
		dco_trim <= 8'd4;
		for (i = 0; i < 2; i++) begin
			dpll_locked <= i[0];
			repeat (100) @(posedge sys_clk);
			count(4, W, c);
			near(c, i ? W * 10 / (2 * R0H) / 8 : W / TK / 8, 3);
			count(0, W, c);
			near(c, ratio(W / TK, 16'(4 + 4 * i), 4) / 2, 2);
			near(ref_freq_ff, TK * 10 / (2 * R0H), 1);
		end
		// Duty of every divider; half of zero acts as one
		dpll_locked <= 1'b0;
		synth_m <= 16'd1;
		synth_n <= 16'd1;
		for (i = 0; i < N_DIV; i++) div_half[i] <= 16'(i);
		repeat (200) @(posedge sys_clk);
		for (i = 0; i < N_DIV; i++) begin
			wait_lvl(i, 0, c);
			wait_lvl(i, 1, c);
			wait_lvl(i, 0, hi);
			wait_lvl(i, 1, lo);
			check(hi, lo);
			check(hi, TK * (i == 0 ? 1 : i));
		end
		// Strap codes 0 to 2; reset also realigns the dividers for skew
		k = $unsigned($random(seed)) % 16;
		div_half[3:2] <= {2{16'd2}};
		se_skew[1] <= k[3:0];
		for (a = 0; a < 3; a++) do_reset(2'(a));
		repeat (60) @(posedge sys_clk);
		check(mclk_ok_ff, 1'b0);
		wait_lvl(2, 0, c);
		wait_lvl(2, 1, c);
		wait_lvl(3, 1, c);
		check(c, k);
		// Pins alone ignored, then div2 stopped high by register, div3 low by pin
		stop_pin <= 2'b11;
		count(3, 200, c);
		check(c > 0, 1'b1);
		stop_edge <= 2'b01;
		stop_reg <= 2'b01;
		stop_pin_en <= 2'b10;
		repeat (100) @(posedge sys_clk);
		count(2, 100, c);
		check(c, 0);
		count(3, 100, c);
		check(c, 0);
		check(clk_out_ff[3:2], 2'b01);
		stop_reg <= 2'b00;
		wait_lvl(2, 0, c);
		near(c, 33, 11);
		// Output mux: oscillator, crystal, forced low, divider
		stop_pin_en <= 2'b00;
		drv_sel <= {DRV_DIVIDER, 2'h3, DRV_XTAL, DRV_OSC};
		repeat (20) @(posedge sys_clk);
		count(0, W, c);
		near(c, W * 10 / (2 * OH), 2);
		count(1, W, c);
		near(c, W * 10 / (2 * XH), 2);
		count(2, W, c);
		check(c, 0);
		count(3, W, c);
		check(c > 0, 1'b1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
